// ---- logic/rdhp_pkg.sv ----
// Shared constants and helpers for the RAM-DAC host register port
package rdhp_pkg;
	// ----------------------------------------
	// Link encoding
	// ----------------------------------------
	localparam int DATA_W = 10;
	localparam logic [1:0] CS_POINTER = 2'h0;
	localparam logic [1:0] CS_PALETTE = 2'h1;
	localparam logic [1:0] CS_CONTROL = 2'h2;
	localparam logic [1:0] CS_MODE = 2'h3;
	// ----------------------------------------
	// Pointer targets for control-select 10
	// ----------------------------------------
	localparam logic [7:0] PTR_PALETTE = 8'h00;
	localparam logic [7:0] PTR_PIXEL_MASK = 8'h04;
	localparam logic [7:0] PTR_CMD_ONE = 8'h05;
	localparam logic [7:0] PTR_CMD_TWO = 8'h06;
	localparam logic [7:0] PTR_CMD_THREE = 8'h07;
	// ----------------------------------------
	// Reset values and field positions
	// ----------------------------------------
	localparam logic [7:0] POINTER_RESET = 8'h00;
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [7:0] PIXEL_MASK_RESET = 8'hFF;
	localparam logic [7:0] CMD_RESET = 8'h00;
	localparam int MODE_PIPE_RST_POS = 0;
	localparam int MODE_BUS8_POS = 1;
	localparam int MODE_DAC8_POS = 2;
	localparam int MODE_LOAD_SYNC_POS = 5;
	localparam int CR1_CAL_VSYNC_POS = 0;
	localparam int CR2_COLOR_LSB = 5;
	localparam logic [2:0] CR2_COLOR_24 = 3'h7;
	localparam int CR2_PEDESTAL_POS = 3;
	localparam int CR2_SYNC_POS = 2;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 4;
	localparam int STROBE_MIN_NS = 16;
	localparam int STROBE_CYCLES = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// ----------------------------------------
	// Controller registers on APB
	// ----------------------------------------
	localparam logic [11:0] HOST_CMD_OFF = 12'h000;
	localparam logic [11:0] HOST_STAT_OFF = 12'h004;
	localparam logic [11:0] HOST_RDATA_OFF = 12'h008;
	localparam int CMD_CS_LSB = 10;
	localparam int CMD_RW_POS = 12;
	localparam int STAT_BUSY_POS = 0;
	localparam int STAT_VALID_POS = 1;

	// Steps a three-write pattern first, not first, first; {fire, stage}
	function automatic logic [2:0] rdhp_seq_step(input logic [1:0] stage,
			input logic bit_val, input logic first);
		logic [2:0] res;
		res = 3'h0;
		case (stage)
			2'h0: res = (bit_val == first) ? 3'h1 : 3'h0;
			2'h1: res = (bit_val != first) ? 3'h2 : 3'h1;
			2'h2: res = (bit_val == first) ? 3'h5 : 3'h0;
			default: res = 3'h0;
		endcase
		return res;
	endfunction
endpackage

// ---- logic/rdhp_link_if.sv ----
// Parallel register link between the host controller and the RAM-DAC port
`timescale 1ns/10ps
interface rdhp_link_if
	import rdhp_pkg::*;
#(
	parameter int DW = DATA_W
) ();
	logic control_select_high;
	logic control_select_low;
	logic rd_wr;
	logic strobe_n;
	logic [DW-1:0] host_data;
	logic host_data_oe_n;
	logic [DW-1:0] dev_data;
	logic dev_data_oe_n;
	logic [DW-1:0] data;

	// Undriven bus floats high through the board pull-ups
	assign data = !dev_data_oe_n ? dev_data : (!host_data_oe_n ? host_data : {DW{1'b1}});

	modport host (
		output control_select_high, control_select_low, rd_wr, strobe_n,
		output host_data, host_data_oe_n,
		input data
	);
	modport dev (
		input control_select_high, control_select_low, rd_wr, strobe_n,
		output dev_data, dev_data_oe_n,
		input data
	);
endinterface

// ---- logic/rdhp_device.sv ----
// RAM-DAC end of the parallel register and palette port
// Overview of operation
// R1: Pointer write via select 00; 00H selects palette
// R2: Palette entry written red, green, blue via 01
// R3: After blue, pointer advances to next location
// R4: Pipe bit 1,0,1 resets pixel pipelines
// R5: Load-sync bit 0,1,0 resynchronises load clocks
// R6: Mode via 11; resets to normal 10-bit
// R7: Mask FFH via 10 leaves pixels unmasked
// R8: Pointer 05H routes select 10 to command one
// R9: Command one enables calibration every vsync
// R10: Command two sets color, pedestal, sync
// R11: Pointer 06H/07H select command two/three
// R12: Read returns currently selected register value
// R13: Host holds selects stable through strobe
`timescale 1ns/10ps
module rdhp_device
	import rdhp_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Register link
	rdhp_link_if.dev link,
	// Video timing pin
	input wire logic vsync_i,
	// Register contents
	output logic [7:0] pixel_mask_o,
	output logic [7:0] mode_o,
	output logic [7:0] cmd_one_o,
	output logic [7:0] cmd_two_o,
	output logic [7:0] cmd_three_o,
	// Decoded controls
	output logic color24_o,
	output logic pedestal_o,
	output logic sync_on_output_o,
	output logic pipe_reset_o,
	output logic load_sync_o,
	output logic cal_start_o,
	// Palette write port toward the pixel path
	output logic pal_we_o,
	output logic [7:0] pal_addr_o,
	output logic [3*DATA_W-1:0] pal_data_o
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	logic strb_prev_reg, strb_prev_next;
	logic [7:0] pointer_register_reg, pointer_register_next;
	logic [7:0] mode_register_main_reg, mode_register_main_next;
	logic [7:0] pixel_mask_register_reg, pixel_mask_register_next;
	logic [7:0] command_reg_one_reg, command_reg_one_next;
	logic [7:0] command_reg_two_reg, command_reg_two_next;
	logic [7:0] command_reg_three_reg, command_reg_three_next;
	logic [1:0] color_reg, color_next;
	logic [DATA_W-1:0] red_hold_reg, red_hold_next, green_hold_reg, green_hold_next;
	logic [1:0] pipe_stage_reg, pipe_stage_next, sync_stage_reg, sync_stage_next;
	logic pipe_reset_reg, pipe_reset_next;
	logic load_sync_reg, load_sync_next;
	logic [DATA_W-1:0] rd_data_reg, rd_data_next;
	logic rd_oe_n_reg, rd_oe_n_next;
	logic pal_we_reg, pal_we_next;
	logic [7:0] pal_addr_reg, pal_addr_next;
	logic [3*DATA_W-1:0] pal_data_reg, pal_data_next;
	logic vs_meta_reg, vs_s2_reg, vs_s3_reg;
	logic vs_level_reg, vs_level_next, cal_reg, cal_next, color24_reg, color24_next;
	logic [3*DATA_W-1:0] pal_mem [256];

	logic start;
	logic [1:0] cs;
	logic [DATA_W-1:0] din;
	logic [3*DATA_W-1:0] entry;
	logic [2:0] pipe_step, sync_step;

	// ----------------------------------------
	// Register port
	// ----------------------------------------
	always_comb begin
		strb_prev_next = link.strobe_n;
		pointer_register_next = pointer_register_reg;
		mode_register_main_next = mode_register_main_reg;
		pixel_mask_register_next = pixel_mask_register_reg;
		command_reg_one_next = command_reg_one_reg;
		command_reg_two_next = command_reg_two_reg;
		command_reg_three_next = command_reg_three_reg;
		color_next = color_reg;
		red_hold_next = red_hold_reg;
		green_hold_next = green_hold_reg;
		pipe_stage_next = pipe_stage_reg;
		sync_stage_next = sync_stage_reg;
		pipe_reset_next = 1'b0;
		load_sync_next = 1'b0;
		rd_data_next = rd_data_reg;
		pal_we_next = 1'b0;
		pal_addr_next = pal_addr_reg;
		pal_data_next = pal_data_reg;
		// Only the opening edge acts, so a long strobe still hits one target
		start = strb_prev_reg && !link.strobe_n; // R13
		cs = {link.control_select_high, link.control_select_low};
		din = link.data;
		entry = pal_mem[pointer_register_reg];
		pipe_step = rdhp_seq_step(pipe_stage_reg, din[MODE_PIPE_RST_POS], 1'b1);
		sync_step = rdhp_seq_step(sync_stage_reg, din[MODE_LOAD_SYNC_POS], 1'b0);
		// Driver turns on one cycle after the read strobe falls and stays on until one cycle after it rises
		rd_oe_n_next = !(!link.strobe_n && link.rd_wr);
		if (start && !link.rd_wr) begin
			case (cs)
				CS_POINTER: begin
					pointer_register_next = din[7:0]; // R1
					color_next = 2'h0;
				end
				CS_PALETTE: begin
					case (color_reg) // R2
						2'h0: begin
							red_hold_next = din;
							color_next = 2'h1;
						end
						2'h1: begin
							green_hold_next = din;
							color_next = 2'h2;
						end
						default: begin
							pal_we_next = 1'b1;
							pal_addr_next = pointer_register_reg;
							pal_data_next = {red_hold_reg, green_hold_reg, din};
							pointer_register_next = pointer_register_reg + 8'h01; // R3
							color_next = 2'h0;
						end
					endcase
				end
				CS_CONTROL: begin
					case (pointer_register_reg)
						PTR_PIXEL_MASK: pixel_mask_register_next = din[7:0]; // R7
						PTR_CMD_ONE: command_reg_one_next = din[7:0]; // R8
						PTR_CMD_TWO: command_reg_two_next = din[7:0]; // R11
						PTR_CMD_THREE: command_reg_three_next = din[7:0]; // R11
						default: ;
					endcase
				end
				default: begin
					mode_register_main_next = din[7:0]; // R6
					pipe_stage_next = pipe_step[1:0];
					pipe_reset_next = pipe_step[2]; // R4
					sync_stage_next = sync_step[1:0];
					load_sync_next = sync_step[2]; // R5
				end
			endcase
		end
		if (start && link.rd_wr) begin
			rd_data_next = '0;
			case (cs) // R12
				CS_POINTER: rd_data_next[7:0] = pointer_register_reg;
				CS_PALETTE: begin
					case (color_reg)
						2'h0: rd_data_next = entry[3*DATA_W-1:2*DATA_W];
						2'h1: rd_data_next = entry[2*DATA_W-1:DATA_W];
						default: rd_data_next = entry[DATA_W-1:0];
					endcase
					// Reads walk the palette the same way as writes
					color_next = (color_reg == 2'h2) ? 2'h0 : color_reg + 2'h1;
					pointer_register_next = pointer_register_reg + {7'h00, color_reg == 2'h2};
				end
				CS_CONTROL: begin
					case (pointer_register_reg)
						PTR_PIXEL_MASK: rd_data_next[7:0] = pixel_mask_register_reg;
						PTR_CMD_ONE: rd_data_next[7:0] = command_reg_one_reg;
						PTR_CMD_TWO: rd_data_next[7:0] = command_reg_two_reg;
						PTR_CMD_THREE: rd_data_next[7:0] = command_reg_three_reg;
						default: rd_data_next = '0;
					endcase
				end
				default: rd_data_next[7:0] = mode_register_main_reg;
			endcase
		end
		color24_next = command_reg_two_next[CR2_COLOR_LSB+:3] == CR2_COLOR_24; // R10
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			strb_prev_reg <= 1'b1;
			pointer_register_reg <= POINTER_RESET;
			mode_register_main_reg <= MODE_RESET; // R6
			pixel_mask_register_reg <= PIXEL_MASK_RESET;
			command_reg_one_reg <= CMD_RESET;
			command_reg_two_reg <= CMD_RESET;
			command_reg_three_reg <= CMD_RESET;
			color_reg <= 2'h0;
			red_hold_reg <= '0;
			green_hold_reg <= '0;
			pipe_stage_reg <= 2'h0;
			sync_stage_reg <= 2'h0;
			pipe_reset_reg <= 1'b0;
			load_sync_reg <= 1'b0;
			rd_data_reg <= '0;
			rd_oe_n_reg <= 1'b1;
			pal_we_reg <= 1'b0;
			pal_addr_reg <= 8'h00;
			pal_data_reg <= '0;
			color24_reg <= 1'b0;
		end else begin
			strb_prev_reg <= strb_prev_next;
			pointer_register_reg <= pointer_register_next;
			mode_register_main_reg <= mode_register_main_next;
			pixel_mask_register_reg <= pixel_mask_register_next;
			command_reg_one_reg <= command_reg_one_next;
			command_reg_two_reg <= command_reg_two_next;
			command_reg_three_reg <= command_reg_three_next;
			color_reg <= color_next;
			red_hold_reg <= red_hold_next;
			green_hold_reg <= green_hold_next;
			pipe_stage_reg <= pipe_stage_next;
			sync_stage_reg <= sync_stage_next;
			pipe_reset_reg <= pipe_reset_next;
			load_sync_reg <= load_sync_next;
			rd_data_reg <= rd_data_next;
			rd_oe_n_reg <= rd_oe_n_next;
			pal_we_reg <= pal_we_next;
			pal_addr_reg <= pal_addr_next;
			pal_data_reg <= pal_data_next;
			color24_reg <= color24_next;
		end
	end

	// Palette storage has no reset; software loads every entry
	always_ff @(posedge clk_i) begin
		if (pal_we_next) begin
			pal_mem[pal_addr_next] <= pal_data_next; // R2
		end
	end

	// ----------------------------------------
	// Calibration trigger
	// ----------------------------------------
	always_comb begin
		vs_level_next = (vs_s2_reg == vs_s3_reg) ? vs_s3_reg : vs_level_reg;
		cal_next = vs_level_next && !vs_level_reg && command_reg_one_reg[CR1_CAL_VSYNC_POS]; // R9
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			vs_meta_reg <= 1'b0;
			vs_s2_reg <= 1'b0;
			vs_s3_reg <= 1'b0;
			vs_level_reg <= 1'b0;
			cal_reg <= 1'b0;
		end else begin
			vs_meta_reg <= vsync_i;
			vs_s2_reg <= vs_meta_reg;
			vs_s3_reg <= vs_s2_reg;
			vs_level_reg <= vs_level_next;
			cal_reg <= cal_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign link.dev_data = rd_data_reg;
	assign link.dev_data_oe_n = rd_oe_n_reg;
	assign pixel_mask_o = pixel_mask_register_reg;
	assign mode_o = mode_register_main_reg;
	assign cmd_one_o = command_reg_one_reg;
	assign cmd_two_o = command_reg_two_reg;
	assign cmd_three_o = command_reg_three_reg;
	assign color24_o = color24_reg; // R10
	assign pedestal_o = command_reg_two_reg[CR2_PEDESTAL_POS]; // R10
	assign sync_on_output_o = command_reg_two_reg[CR2_SYNC_POS]; // R10
	assign pipe_reset_o = pipe_reset_reg;
	assign load_sync_o = load_sync_reg;
	assign cal_start_o = cal_reg;
	assign pal_we_o = pal_we_reg;
	assign pal_addr_o = pal_addr_reg;
	assign pal_data_o = pal_data_reg;
endmodule

// ---- logic/rdhp_host.sv ----
// Host controller: APB command registers driving the parallel register link
`timescale 1ns/10ps
module rdhp_host
	import rdhp_pkg::*;
#(
	parameter int STROBE_LEN = STROBE_CYCLES
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Register link
	rdhp_link_if.host link
);
	// Device drives read data one cycle into the strobe
	if (STROBE_LEN < 2 || STROBE_LEN > 255) begin : g_len_check
		$error("STROBE_LEN must lie in 2..255");
	end

	typedef enum logic [3:0] {
		RDHP_IDLE = 4'h1,
		RDHP_SETUP = 4'h2,
		RDHP_STROBE = 4'h4,
		RDHP_HOLD = 4'h8
	} rdhp_state_t;

	// ----------------------------------------
	// State
	// ----------------------------------------
	rdhp_state_t state_reg, state_next;
	logic [7:0] cnt_reg, cnt_next;
	logic [12:0] cmd_reg, cmd_next;
	logic [DATA_W-1:0] rdata_reg, rdata_next;
	logic valid_reg, valid_next;
	logic strb_n_reg, strb_n_next;
	logic oe_n_reg, oe_n_next;
	logic pready_reg, pready_next;
	logic pslverr_reg, pslverr_next;
	logic [31:0] prdata_reg, prdata_next;
	logic access, commit, busy, mapped, refuse, go;

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		cmd_next = cmd_reg;
		rdata_next = rdata_reg;
		valid_next = valid_reg;
		strb_n_next = strb_n_reg;
		oe_n_next = oe_n_reg;
		pready_next = 1'b0;
		pslverr_next = 1'b0;
		prdata_next = prdata_reg;
		busy = state_reg != RDHP_IDLE;
		mapped = paddr_i == HOST_CMD_OFF || paddr_i == HOST_STAT_OFF || paddr_i == HOST_RDATA_OFF;
		refuse = !mapped || (pwrite_i && paddr_i == HOST_CMD_OFF && busy);
		// Answer one cycle into the access phase
		access = psel_i && penable_i && !pready_reg;
		commit = psel_i && penable_i && pready_reg && !pslverr_reg;
		go = commit && pwrite_i && paddr_i == HOST_CMD_OFF;
		if (access) begin
			pready_next = 1'b1;
			pslverr_next = refuse;
			prdata_next = 32'h0000_0000;
			if (paddr_i == HOST_CMD_OFF) begin
				prdata_next[12:0] = cmd_reg;
			end else if (paddr_i == HOST_STAT_OFF) begin
				prdata_next[STAT_BUSY_POS] = busy;
				prdata_next[STAT_VALID_POS] = valid_reg;
			end else if (paddr_i == HOST_RDATA_OFF) begin
				prdata_next[DATA_W-1:0] = rdata_reg;
			end
		end
		if (commit && !pwrite_i && paddr_i == HOST_RDATA_OFF) begin
			valid_next = 1'b0;
		end
		case (state_reg)
			RDHP_IDLE: begin
				if (go) begin
					cmd_next = pwdata_i[12:0];
					oe_n_next = pwdata_i[CMD_RW_POS];
					state_next = RDHP_SETUP;
				end
			end
			RDHP_SETUP: begin
				strb_n_next = 1'b0;
				cnt_next = 8'(STROBE_LEN - 1);
				state_next = RDHP_STROBE;
			end
			RDHP_STROBE: begin
				// Selects, direction and data stay put while the strobe is low
				if (cnt_reg == 8'h00) begin // R13
					strb_n_next = 1'b1;
					state_next = RDHP_HOLD;
					if (cmd_reg[CMD_RW_POS]) begin
						rdata_next = link.data; // R12
						valid_next = 1'b1;
					end
				end else begin
					cnt_next = cnt_reg - 8'h01;
				end
			end
			RDHP_HOLD: begin
				oe_n_next = 1'b1;
				state_next = RDHP_IDLE;
			end
			default: state_next = RDHP_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state_reg <= RDHP_IDLE;
			cnt_reg <= 8'h00;
			cmd_reg <= 13'h0000;
			rdata_reg <= '0;
			valid_reg <= 1'b0;
			strb_n_reg <= 1'b1;
			oe_n_reg <= 1'b1;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			cmd_reg <= cmd_next;
			rdata_reg <= rdata_next;
			valid_reg <= valid_next;
			strb_n_reg <= strb_n_next;
			oe_n_reg <= oe_n_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
			prdata_reg <= prdata_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign link.control_select_high = cmd_reg[CMD_CS_LSB+1]; // R1
	assign link.control_select_low = cmd_reg[CMD_CS_LSB];
	assign link.rd_wr = cmd_reg[CMD_RW_POS];
	assign link.strobe_n = strb_n_reg;
	assign link.host_data = cmd_reg[DATA_W-1:0];
	assign link.host_data_oe_n = oe_n_reg;
	assign prdata_o = prdata_reg;
	assign pready_o = pready_reg;
	assign pslverr_o = pslverr_reg;
endmodule

// ---- tb/rdhp_link_sva.sv ----
// Protocol checker for the parallel register link between host and device
`timescale 1ns/10ps
module rdhp_link_sva #(
	parameter int STROBE_LEN = 4,
	parameter int DW = 10
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Link signals
	input wire logic control_select_high,
	input wire logic control_select_low,
	input wire logic rd_wr,
	input wire logic strobe_n,
	input wire logic [DW-1:0] host_data,
	input wire logic host_data_oe_n,
	input wire logic dev_data_oe_n
);
	// ----------------------------------------
	// Strobe length counter
	// ----------------------------------------
	int low_cnt_reg;
	int low_cnt_next;
	always_comb begin
		low_cnt_next = strobe_n ? 0 : low_cnt_reg + 1;
	end
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			low_cnt_reg <= 0;
		end else begin
			low_cnt_reg <= low_cnt_next;
		end
	end
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	sequence strobe_start_s;
		$fell(strobe_n);
	endsequence
	sequence strobe_end_s;
		$rose(strobe_n);
	endsequence
	sequence dev_release_s;
		!dev_data_oe_n ##1 dev_data_oe_n;
	endsequence
	strobe_len_a: assert property (strobe_end_s |-> low_cnt_reg == STROBE_LEN)
		else $error("strobe length wrong");
	sel_stable_a: assert property (!strobe_n && $past(!strobe_n) |->
		$stable({control_select_high, control_select_low, rd_wr, host_data}))
		else $error("select changed under strobe");
	setup_ahead_a: assert property (strobe_start_s |->
		$stable({control_select_high, control_select_low, rd_wr, host_data})
		&& (rd_wr || (!host_data_oe_n && $past(!host_data_oe_n))))
		else $error("no setup cycle before strobe");
	read_drive_a: assert property (strobe_start_s ##0 rd_wr |=> !dev_data_oe_n)
		else $error("device late on read");
	read_hold_a: assert property (!strobe_n && $past(!strobe_n) && rd_wr |-> !dev_data_oe_n)
		else $error("device dropped read data");
	read_release_a: assert property (strobe_end_s ##0 rd_wr |-> dev_release_s)
		else $error("device release timing wrong");
	write_quiet_a: assert property (!rd_wr && !strobe_n |-> dev_data_oe_n)
		else $error("device drives during write");
	bus_clash_a: assert property (!(!dev_data_oe_n && !host_data_oe_n))
		else $error("both ends drive the bus");
	host_oe_a: assert property (!host_data_oe_n |-> !rd_wr)
		else $error("host drives during read");
	idle_gap_a: assert property (strobe_end_s |-> strobe_n [*3])
		else $error("strobes too close");
endmodule

// ---- tb/rdhp_tb.sv ----
// Self-checking bench: host controller and device joined by the link
`timescale 1ns/10ps
module rdhp_tb
	import rdhp_pkg::*;
;
	localparam int SL = 4;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [11:0] paddr_i = 12'h000;
	logic [31:0] pwdata_i = 32'h0000_0000;
	logic vsync_i = 1'b0;
	logic [31:0] prdata_o;
	logic pready_o, pslverr_o, color24_o, pedestal_o, sync_on_output_o;
	logic pipe_reset_o, load_sync_o, cal_start_o, pal_we_o;
	logic [7:0] pixel_mask_o, mode_o, cmd_one_o, cmd_two_o, cmd_three_o, pal_addr_o, v;
	logic [3*DATA_W-1:0] pal_data_o;
	logic [29:0] ent;
	logic [9:0] rd;
	logic [31:0] r;
	logic e;
	logic [7:0] mdl[8];
	logic [7:0] mseq[6] = '{8'h01, 8'h00, 8'h01, 8'h00, 8'h20, 8'h04};
	logic [37:0] pal_q[$];
	logic [37:0] exp_q[$];
	int error_cnt = 0;
	int total_checks = 0;
	int n_pipe = 0, n_sync = 0, n_cal = 0;
	wire logic [31:0] regs_v = {cmd_three_o, cmd_two_o, cmd_one_o, pixel_mask_o};

	initial begin
		forever #2 clk_i = ~clk_i;
	end
	rdhp_link_if u_link ();
	rdhp_host #(.STROBE_LEN(SL)) u_rdhp_host (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .link(u_link.host));
	rdhp_device u_rdhp_device (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .link(u_link.dev),
		.vsync_i(vsync_i), .pixel_mask_o(pixel_mask_o), .mode_o(mode_o),
		.cmd_one_o(cmd_one_o), .cmd_two_o(cmd_two_o), .cmd_three_o(cmd_three_o),
		.color24_o(color24_o), .pedestal_o(pedestal_o), .sync_on_output_o(sync_on_output_o),
		.pipe_reset_o(pipe_reset_o), .load_sync_o(load_sync_o), .cal_start_o(cal_start_o),
		.pal_we_o(pal_we_o), .pal_addr_o(pal_addr_o), .pal_data_o(pal_data_o));
	rdhp_link_sva #(.STROBE_LEN(SL), .DW(DATA_W)) u_sva (.clk_i(clk_i),
		.sys_rst_i(sys_rst_i), .control_select_high(u_link.control_select_high),
		.control_select_low(u_link.control_select_low), .rd_wr(u_link.rd_wr),
		.strobe_n(u_link.strobe_n), .host_data(u_link.host_data),
		.host_data_oe_n(u_link.host_data_oe_n), .dev_data_oe_n(u_link.dev_data_oe_n));

	// Pulses are one cycle wide, so they are counted at every edge
	always @(posedge clk_i) begin
		if (pal_we_o === 1'b1) pal_q.push_back({pal_addr_o, pal_data_o});
		if (pipe_reset_o === 1'b1) n_pipe++;
		if (load_sync_o === 1'b1) n_sync++;
		if (cal_start_o === 1'b1) n_cal++;
	end

	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic er);
		@(posedge clk_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge clk_i);
		end while (pready_o !== 1'b1);
		q = prdata_o;
		er = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask

	// One link access: command, poll busy, fetch read data
	task automatic link(input logic rw, input logic [1:0] cs, input logic [9:0] d,
			output logic [9:0] q);
		logic [31:0] t;
		logic er;
		apb(1'b1, HOST_CMD_OFF, {19'h0_0000, rw, cs, d}, t, er);
		do begin
			apb(1'b0, HOST_STAT_OFF, 32'h0000_0000, t, er);
		end while (t[STAT_BUSY_POS] !== 1'b0);
		q = 10'h000;
		if (rw) begin
			apb(1'b0, HOST_RDATA_OFF, 32'h0000_0000, t, er);
			q = t[9:0];
		end
	endtask

	task automatic close_out();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk_i);
		error_cnt++;
		close_out();
	end

	initial begin
		void'($urandom(32'h6d9f));
		repeat (4) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		for (int p = 4; p < 8; p++) begin
			link(1'b0, CS_POINTER, 10'(p), rd);
			link(1'b1, CS_CONTROL, 10'h000, rd);
			chk("ctl reset", rd, (p == 4) ? PIXEL_MASK_RESET : CMD_RESET);
			v = 8'($urandom);
			mdl[p] = v;
			link(1'b0, CS_CONTROL, {2'b00, v}, rd);
			link(1'b1, CS_CONTROL, 10'h000, rd);
			chk("ctl readback", rd, mdl[p]);
			chk("ctl output", regs_v[(p - 4) * 8 +: 8], mdl[p]);
		end
		// Unselected pointer: write ignored, read gives zero
		link(1'b0, CS_POINTER, 10'h003, rd);
		link(1'b0, CS_CONTROL, 10'h0AA, rd);
		link(1'b1, CS_CONTROL, 10'h000, rd);
		chk("reserved read", rd, 10'h000);
		link(1'b0, CS_POINTER, 10'h006, rd);
		link(1'b0, CS_CONTROL, 10'h0E0, rd);
		chk("cmd two decode", {color24_o, pedestal_o, sync_on_output_o}, 3'b100);
		link(1'b0, CS_CONTROL, 10'h00C, rd);
		chk("cmd two fields", {color24_o, pedestal_o, sync_on_output_o}, 3'b011);
		$display("test registers done");
		link(1'b1, CS_MODE, 10'h000, rd);
		chk("mode reset", rd, MODE_RESET);
		for (int i = 0; i < 6; i++) link(1'b0, CS_MODE, {2'b00, mseq[i]}, rd);
		repeat (4) @(posedge clk_i);
		chk("pipe pulses", n_pipe, 1);
		chk("sync pulses", n_sync, 1);
		chk("mode value", mode_o, mseq[5]);
		link(1'b1, CS_MODE, 10'h000, rd);
		chk("mode readback", rd, mseq[5]);
		$display("test mode done");
		foreach (mdl[s]) begin
			if (s == 0 || s == 7) begin
				link(1'b0, CS_POINTER, (s == 0) ? 10'h000 : 10'h0FF, rd);
				for (int k = 0; k < 2; k++) begin
					ent = 30'($urandom);
					for (int c = 0; c < 3; c++) link(1'b0, CS_PALETTE, ent[29 - 10 * c -: 10], rd);
					exp_q.push_back({8'((s == 0) ? k : 255 + k), ent});
				end
			end
		end
		repeat (4) @(posedge clk_i);
		chk("palette count", pal_q.size(), exp_q.size());
		for (int i = 0; i < exp_q.size(); i++) begin
			chk("palette entry", (i < pal_q.size()) ? pal_q[i] : 38'h0, exp_q[i]);
		end
		link(1'b0, CS_POINTER, 10'h001, rd);
		for (int c = 0; c < 3; c++) begin
			link(1'b1, CS_PALETTE, 10'h000, rd);
			chk("palette read", rd, exp_q[1][29 - 10 * c -: 10]);
		end
		$display("test palette done");
		for (int b = 0; b < 2; b++) begin
			link(1'b0, CS_POINTER, 10'h005, rd);
			link(1'b0, CS_CONTROL, 10'(b), rd);
			n_cal = 0;
			vsync_i <= 1'b1;
			repeat (8) @(posedge clk_i);
			vsync_i <= 1'b0;
			repeat (10) @(posedge clk_i);
			chk("cal pulses", n_cal, b);
		end
		apb(1'b0, 12'h010, 32'h0000_0000, r, e);
		chk("unmapped error", e, 1'b1);
		apb(1'b0, HOST_CMD_OFF, 32'h0000_0000, r, e);
		chk("last command", r, {19'h0_0000, 1'b0, CS_CONTROL, 10'h001});
		$display("test vsync and bus done");
		close_out();
	end
endmodule
